// ===== common/spi_port_pkg.sv
// Operation
// - Software waits for shift end before rewriting
// - Unread received byte is overwritten by next
// - Enable overrides pin directions per role
// - Master data write shifts eight bits, flags
// - Last master byte, or slave byte in modes 0 and 3, kept in buffer
// - Low select input in master forces slave
// - Deselected slave idles, output released
// - Selected slave shifts, flags each byte
// - Select release resets slave shift logic
// - Launch and capture on opposite edges
// - DMA request per slave byte only
// - Master clock divider from prescaler, doubling
// - Nothing happens unless enable bit set
// - Bit order select picks lsb first
// - Master select bit picks role
// - Mode bits set polarity and phase
// - Nonzero level enables request on flag
// - Flag cleared by vector or read sequence
// - Collision flag on write during transfer
// - Data reads received byte, writes transmit byte
package spi_port_pkg;

   // Register indices; the byte address is four times the index.
   localparam logic [1:0] IDX_CONTROL   = 2'h0;
   localparam logic [1:0] IDX_INT_CTRL  = 2'h1;
   localparam logic [1:0] IDX_STATUS    = 2'h2;
   localparam logic [1:0] IDX_DATA      = 2'h3;

   // Control register fields.
   localparam int CTL_CLOCK_DOUBLE = 7;
   localparam int CTL_ENABLE       = 6;
   localparam int CTL_BIT_ORDER    = 5;
   localparam int CTL_MASTER       = 4;
   localparam int CTL_CPOL         = 3;
   localparam int CTL_CPHA         = 2;
   localparam int CTL_PRESC_HI     = 1;

   // Status register fields.
   localparam int STS_DONE         = 7;
   localparam int STS_COLLISION    = 6;

   // Reset values.
   localparam logic [7:0] CONTROL_RESET  = 8'h00;
   localparam logic [1:0] LEVEL_RESET    = 2'h0;

   // Frame geometry.
   localparam logic [2:0] LAST_BIT       = 3'h7;
   localparam logic [3:0] LAST_EDGE      = 4'hf;

   // Half-period of the master clock in peripheral clocks, indexed by
   // {clock_double, prescaler}: divides of 4,16,64,128 then 2,8,32,64.
   localparam logic [6:0] HALF_TABLE [8] = '{
      7'h02, 7'h08, 7'h20, 7'h40, 7'h01, 7'h04, 7'h10, 7'h20
   };

   // AXI responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : spi_port_pkg

// ===== core/spi_master_slave_port.sv
`timescale 1ns/1ps
module spi_master_slave_port
   import spi_port_pkg::*;
#(
   parameter int ADDR_W = 4
) (
   // Clock and reset.
   input  wire logic              mclk,
   input  wire logic              rst_n,
   // AXI4-Lite write address and data.
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   // AXI4-Lite write response.
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // AXI4-Lite read.
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // User pin directions and software select level.
   input  wire logic              mosiDirUser,
   input  wire logic              misoDirUser,
   input  wire logic              sckDirUser,
   input  wire logic              ssDirUser,
   input  wire logic              ssLevelUser,
   // Serial pins, each as input, output and output enable.
   input  wire logic              mosiIn,
   output logic                   mosiOut,
   output logic                   mosiOe,
   input  wire logic              misoIn,
   output logic                   misoOut,
   output logic                   misoOe,
   input  wire logic              sckIn,
   output logic                   sckOut,
   output logic                   sckOe,
   input  wire logic              ssIn_n,
   output logic                   ssOut_n,
   output logic                   ssOe,
   // Interrupt request, level, vector acknowledge and DMA trigger.
   output logic                   irqReq,
   output logic [1:0]             irqLevel,
   input  wire logic              irqAck,
   output logic                   dmaReq
);

   logic [7:0]        ctrl;
   logic              doneFlag;
   logic              colFlag;
   logic              armDone;
   logic              armCol;
   logic [7:0]        rxBuf;
   logic [7:0]        sh;
   logic [2:0]        bitCnt;
   logic              serBit;
   logic              mBusy;
   logic [3:0]        mEdges;
   logic [6:0]        divCnt;
   logic              awHeld;
   logic              wHeld;
   logic [ADDR_W-1:0] awAddrQ;
   logic [7:0]        wByteQ;
   logic              wLaneQ;
   logic [1:0]        sckSync;
   logic [1:0]        ssSync;
   logic [1:0]        mosiSync;
   logic              sckPrev;

   // Role and mode decode from the control register.
   wire enabled    = ctrl[CTL_ENABLE];
   wire masterOn   = enabled & ctrl[CTL_MASTER];
   wire slaveOn    = enabled & ~ctrl[CTL_MASTER];
   wire cpol       = ctrl[CTL_CPOL];
   wire cpha       = ctrl[CTL_CPHA];
   wire lsbFirst   = ctrl[CTL_BIT_ORDER];
   wire [6:0] half = HALF_TABLE[{ctrl[CTL_CLOCK_DOUBLE],
                                 ctrl[CTL_PRESC_HI:0]}];

   // Synchronised slave-side inputs; the second stage feeds the logic.
   wire sckS       = sckSync[1];
   wire ssS_n      = ssSync[1];
   wire mosiS      = mosiSync[1];

   // Register bus decode.
   wire [1:0] wIdx   = awAddrQ[3:2];
   wire       wInMap = (awAddrQ >> 4) == '0;
   wire [1:0] rIdx   = araddr[3:2];
   wire       rInMap = (araddr >> 4) == '0;
   wire       wrFire = awHeld & wHeld & ~bvalid;
   wire       arFire = arvalid & arready;
   wire       wrHit  = wrFire & wInMap & wLaneQ;
   wire       ctlWr  = wrHit & (wIdx == IDX_CONTROL);
   wire       lvlWr  = wrHit & (wIdx == IDX_INT_CTRL);
   wire       dataWr = wrHit & (wIdx == IDX_DATA);
   wire       dataRd = arFire & rInMap & (rIdx == IDX_DATA);
   wire       statRd = arFire & rInMap & (rIdx == IDX_STATUS);
   wire       dataAc = dataWr | dataRd;

   // Transfer state decode.
   wire slaveSel   = slaveOn & ~ssS_n;
   wire sBusy      = slaveSel & (bitCnt != 3'h0);
   wire collide    = dataWr & (mBusy | sBusy);
   wire startM     = dataWr & masterOn & ~mBusy;
   wire modeFault  = masterOn & ~ssDirUser & ~ssIn_n;
   wire divTick    = mBusy & (divCnt == half - 7'h1);
   wire mRise      = divTick & ~sckOut;
   wire mFall      = divTick & sckOut;
   wire sRise      = slaveSel & sckS & ~sckPrev;
   wire sFall      = slaveSel & ~sckS & sckPrev;
   wire rise       = mRise | sRise;
   wire fall       = mFall | sFall;
   wire sampleRise = ~(cpol ^ cpha);
   wire sampleEdge = sampleRise ? rise : fall;
   wire setupEdge  = sampleRise ? fall : rise;
   wire din        = masterOn ? misoIn : mosiS;
   wire [7:0] shNext = lsbFirst ? {din, sh[7:1]} : {sh[6:0], din};
   wire outSh      = lsbFirst ? sh[0] : sh[7];
   wire outW       = lsbFirst ? wByteQ[0] : wByteQ[7];
   wire mDone      = divTick & (mEdges == LAST_EDGE);
   wire sDone      = slaveSel & sampleEdge & (bitCnt == LAST_BIT);
   wire doneEvt    = (mDone & ~modeFault) | sDone;
   wire rxDone     = sampleRise ? sDone : (mDone & ~modeFault);
   wire [7:0] rxByte = sampleEdge ? shNext : sh;

   // Read data selection.
   wire [7:0] statByte = {doneFlag, colFlag, 6'h00};
   wire [7:0] rdByte   = (rIdx == IDX_CONTROL)  ? ctrl :
                         (rIdx == IDX_INT_CTRL) ? {6'h00, irqLevel} :
                         (rIdx == IDX_STATUS)   ? statByte : rxBuf;

   // Two-stage synchronisers for the slave-side inputs.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sckSync  <= 2'h0;
         ssSync   <= 2'h3;
         mosiSync <= 2'h0;
         sckPrev  <= 1'b0;
      end else begin
         sckSync  <= {sckSync[0], sckIn};
         ssSync   <= {ssSync[0], ssIn_n};
         mosiSync <= {mosiSync[0], mosiIn};
         sckPrev  <= sckS;
      end
   end

   // AXI write channels: address and data are taken in either order.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         awready <= 1'b0;
         wready  <= 1'b0;
         awHeld  <= 1'b0;
         wHeld   <= 1'b0;
         awAddrQ <= '0;
         wByteQ  <= 8'h00;
         wLaneQ  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            awHeld  <= 1'b1;
            awAddrQ <= awaddr;
         end else if (!awHeld && !bvalid) begin
            awready <= 1'b1;
         end
         if (wvalid && wready) begin
            wready <= 1'b0;
            wHeld  <= 1'b1;
            wByteQ <= wdata[7:0];
            wLaneQ <= wstrb[0];
         end else if (!wHeld && !bvalid) begin
            wready <= 1'b1;
         end
         if (wrFire) begin
            awHeld <= 1'b0;
            wHeld  <= 1'b0;
            bvalid <= 1'b1;
            bresp  <= wInMap ? RESP_OKAY : RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // AXI read channel: one read in flight, answered the next cycle.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= RESP_OKAY;
      end else if (arFire) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rInMap ? {24'h00_0000, rdByte} : 32'h0000_0000;
         rresp   <= rInMap ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

   // Control and level registers; a select fault drops the role to slave.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl     <= CONTROL_RESET;
         irqLevel <= LEVEL_RESET;
      end else begin
         if (ctlWr) begin
            ctrl <= wByteQ;
         end
         if (modeFault) begin
            ctrl[CTL_MASTER] <= 1'b0;
         end
         if (lvlWr) begin
            irqLevel <= wByteQ[1:0];
         end
      end
   end

   // Status flags: a setting event wins over any clear in the same cycle.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         doneFlag <= 1'b0;
         colFlag  <= 1'b0;
         armDone  <= 1'b0;
         armCol   <= 1'b0;
      end else begin
         if (doneEvt || modeFault) begin
            doneFlag <= 1'b1;
         end else if (irqAck || (dataAc && armDone)) begin
            doneFlag <= 1'b0;
         end
         if (collide) begin
            colFlag <= 1'b1;
         end else if (dataAc && armCol) begin
            colFlag <= 1'b0;
         end
         if (statRd) begin
            armDone <= doneFlag;
            armCol  <= colFlag;
         end else if (dataAc) begin
            armDone <= 1'b0;
            armCol  <= 1'b0;
         end
      end
   end

   // Receive buffer keeps the last master byte, or slave byte in modes 0 and 3, until the next one.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rxBuf <= 8'h00;
      end else if (rxDone || (mDone && !modeFault)) begin
         rxBuf <= rxByte;
      end
   end

   // Master clock generator and edge counter.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mBusy  <= 1'b0;
         mEdges <= 4'h0;
         divCnt <= 7'h00;
         sckOut <= 1'b0;
      end else if (!masterOn || modeFault) begin
         mBusy  <= 1'b0;
         mEdges <= 4'h0;
         divCnt <= 7'h00;
         sckOut <= cpol;
      end else if (startM) begin
         mBusy  <= 1'b1;
         mEdges <= 4'h0;
         divCnt <= 7'h00;
         sckOut <= cpol;
      end else if (divTick) begin
         divCnt <= 7'h00;
         mEdges <= mEdges + 4'h1;
         sckOut <= ~sckOut;
         if (mDone) begin
            mBusy <= 1'b0;
         end
      end else if (mBusy) begin
         divCnt <= divCnt + 7'h01;
      end else begin
         sckOut <= cpol;
      end
   end

   // Shared shift register: sample edges shift in, setup edges launch.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sh     <= 8'h00;
         bitCnt <= 3'h0;
         serBit <= 1'b0;
      end else if (!enabled) begin
         bitCnt <= 3'h0;
      end else if (slaveOn && ssS_n) begin
         bitCnt <= 3'h0;
         if (dataWr && !collide) begin
            sh <= wByteQ;
         end
      end else if (dataWr && !collide) begin
         sh     <= wByteQ;
         serBit <= outW;
         bitCnt <= 3'h0;
      end else if (sampleEdge) begin
         sh     <= shNext;
         bitCnt <= bitCnt + 3'h1;
      end else if (setupEdge) begin
         serBit <= outSh;
      end else if (slaveSel && bitCnt == 3'h0 && !cpha) begin
         serBit <= outSh;
      end
   end

   // Pin drive; user directions apply only where the role leaves them.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mosiOe  <= 1'b0;
         misoOe  <= 1'b0;
         sckOe   <= 1'b0;
         ssOe    <= 1'b0;
         ssOut_n <= 1'b1;
      end else begin
         mosiOe  <= masterOn & mosiDirUser;
         sckOe   <= masterOn & sckDirUser;
         ssOe    <= masterOn & ssDirUser;
         misoOe  <= slaveSel & misoDirUser;
         ssOut_n <= ssLevelUser;
      end
   end

   // Interrupt request and slave DMA trigger.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irqReq <= 1'b0;
         dmaReq <= 1'b0;
      end else begin
         irqReq <= doneFlag & (irqLevel != 2'h0);
         dmaReq <= sDone;
      end
   end

   // Both data outputs share the launched bit; only one drives at a time.
   assign mosiOut = serBit;
   assign misoOut = serBit;

endmodule : spi_master_slave_port

// ===== verif/spi_slave_model.sv
`timescale 1ns/1ps
module spi_slave_model (
   // Serial pins.
   input  wire logic       sck,
   input  wire logic       ssel_n,
   input  wire logic       mosi,
   output logic            miso,
   // Mode and bytes.
   input  wire logic       sampleRise,
   input  wire logic [7:0] txByte,
   output logic [7:0]      rxByte
);
   logic [7:0] sr = 8'h00;
   logic       last = 1'b0;
   int         nSamp = 0;

   // A released line shows the inverse of its last bit.
   assign miso = ssel_n ? ~last : sr[7];

   // Selection loads the reply and restarts the bit count.
   always @(negedge ssel_n) begin
      sr = txByte;
      nSamp = 0;
   end

   // Remember the last bit for the released level.
   always @(posedge ssel_n) begin
      last = sr[7];
   end

   // Capture on one edge, launch the next bit on the other.
   always @(sck) begin
      if (!ssel_n && sck == sampleRise) begin
         rxByte = {rxByte[6:0], mosi};
         nSamp++;
      end else if (!ssel_n && nSamp != 0) begin
         sr = {sr[6:0], 1'b0};
      end
   end
endmodule : spi_slave_model

// ===== verif/spi_port_chk.sv
`timescale 1ns/1ps
module spi_port_chk (
   // Clock and reset.
   input wire logic       mclk,
   input wire logic       rst_n,
   // Bus handshakes.
   input wire logic       awready,
   input wire logic       wready,
   input wire logic       bvalid,
   input wire logic       arready,
   input wire logic       rvalid,
   // Pins and requests.
   input wire logic       mosiOe,
   input wire logic       misoOe,
   input wire logic       sckOe,
   input wire logic       ssIn_n,
   input wire logic       irqReq,
   input wire logic [1:0] irqLevel,
   input wire logic       irqAck,
   input wire logic       dmaReq
);
   // All checks share one clock and reset.
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_roles; !(sckOe && misoOe); endproperty
   a_roles: assert property (p_roles) else $error("sck and miso driven");
   property p_oe; !(mosiOe && misoOe); endproperty
   a_oe: assert property (p_oe) else $error("mosi and miso driven");
   property p_desel; ssIn_n [*5] |-> !misoOe; endproperty
   a_desel: assert property (p_desel) else $error("miso not released");
   property p_dma_slave; dmaReq |-> !sckOe; endproperty
   a_dma_slave: assert property (p_dma_slave) else $error("dma as master");
   property p_dma_pulse; dmaReq |=> !dmaReq; endproperty
   a_dma_pulse: assert property (p_dma_pulse) else $error("dma too long");
   property p_irq_lvl; irqReq |-> $past(irqLevel) != 2'h0; endproperty
   a_irq_lvl: assert property (p_irq_lvl) else $error("irq at level 0");
   property p_ack; irqAck && irqReq && !dmaReq |=> ##1 !irqReq; endproperty
   a_ack: assert property (p_ack) else $error("irq kept after ack");
   property p_bbusy; bvalid |-> !awready && !wready; endproperty
   a_bbusy: assert property (p_bbusy) else $error("write ready early");
   property p_rbusy; rvalid |-> !arready; endproperty
   a_rbusy: assert property (p_rbusy) else $error("read ready early");
endmodule : spi_port_chk

bind spi_master_slave_port spi_port_chk u_chk (.mclk, .rst_n, .awready,
   .wready, .bvalid, .arready, .rvalid, .mosiOe, .misoOe, .sckOe, .ssIn_n,
   .irqReq, .irqLevel, .irqAck, .dmaReq);

// ===== verif/test_spi_master_slave_port.sv
`timescale 1ns/1ps
`define CHK(n, e, v) begin n_tests++; if ((v) !== (e)) begin err_total++; \
   $display("BAD %s exp %h got %h", n, e, v); end end
module test_spi_master_slave_port;
   import spi_port_pkg::*;
   logic        mclk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic [4:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, irqLevel;
   logic        awready, wready, bvalid, arready, rvalid, irqReq, dmaReq;
   logic        mosiOut, mosiOe, misoOut, misoOe, sckOut, sckOe, ssOut_n;
   logic        ssOe, mosiDirUser, misoDirUser, sckDirUser, ssDirUser;
   logic        ssLevelUser, irqAck, tbSck, tbSs_n, tbMosi, modelMiso;
   logic        sampleRise;
   logic [7:0]  slvTx, slvRx;
   int          err_total, n_tests, nDma;
   localparam int DIV [8] = '{4, 16, 64, 128, 2, 8, 32, 64};
   // Each pin level comes from whoever enables it.
   wire mosiIn = mosiOe ? mosiOut : tbMosi;
   wire misoIn = misoOe ? misoOut : modelMiso;
   wire sckIn  = sckOe ? sckOut : tbSck;
   wire ssIn_n = ssOe ? ssOut_n : tbSs_n;

   spi_master_slave_port #(.ADDR_W(5)) DUT (.mclk, .rst_n, .awaddr,
      .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .mosiDirUser, .misoDirUser, .sckDirUser, .ssDirUser, .ssLevelUser,
      .mosiIn, .mosiOut, .mosiOe, .misoIn, .misoOut, .misoOe, .sckIn,
      .sckOut, .sckOe, .ssIn_n, .ssOut_n, .ssOe, .irqReq, .irqLevel, .irqAck,
      .dmaReq);
   spi_slave_model SLV (.sck(sckIn), .ssel_n(ssIn_n), .mosi(mosiIn),
      .miso(modelMiso), .sampleRise, .txByte(slvTx), .rxByte(slvRx));

   // Free-running clock and a count of slave requests.
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) if (dmaReq === 1'b1) nDma++;

   function automatic logic [7:0] rev(input logic [7:0] v);
      for (int i = 0; i < 8; i++) rev[i] = v[7-i];
   endfunction : rev

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge mclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (awvalid || wvalid);
      while (bvalid !== 1'b1) @(posedge mclk);
      `CHK("bresp", RESP_OKAY, bresp)
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [4:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge mclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge mclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd

   task automatic rchk(input string n, input logic [4:0] a,
                       input logic [7:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      `CHK(n, {24'h0, e}, d)
      `CHK(n, RESP_OKAY, r)
   endtask : rchk

   task automatic waitDone;
      logic [31:0] d;
      logic [1:0]  r;
      d = 0;
      for (int n = 0; n < 2000 && d[7] !== 1'b1; n++) rd(5'h08, d, r);
      `CHK("done", 1'b1, d[7])
   endtask : waitDone

   task automatic t_reset;
      logic [31:0] d;
      logic [1:0]  r;
      rchk("ctl", 5'h00, 8'h00);
      rchk("int", 5'h04, 8'h00);
      rchk("sts", 5'h08, 8'h00);
      rd(5'h10, d, r);
      `CHK("unmapped", RESP_SLVERR, r)
      wr(5'h08, 8'hff);
      rchk("sts ro", 5'h08, 8'h00);
   endtask : t_reset

   task automatic t_master(input logic [1:0] md, input logic lsb,
      input logic dbl, input logic [1:0] pre, input logic [7:0] tx);
      int h;
      sampleRise <= md[1] == md[0];
      slvTx <= ~tx;
      wr(5'h00, {dbl, 1'b1, lsb, 1'b1, md, pre});
      repeat (3) @(posedge mclk);
      `CHK("idle", md[1], sckOut)
      ssLevelUser <= 1'b0;
      repeat (3) @(posedge mclk);
      wr(5'h0c, tx);
      for (h = 0; h < 300 && sckOut === md[1]; h++) @(posedge mclk);
      for (h = 0; h < 300 && sckOut !== md[1]; h++) @(posedge mclk);
      for (h = 0; h < 300 && sckOut === md[1]; h++) @(posedge mclk);
      `CHK("half", DIV[{dbl, pre}] / 2, h)
      waitDone;
      ssLevelUser <= 1'b1;
      `CHK("slave rx", lsb ? rev(tx) : tx, slvRx)
      rchk("rx", 5'h0c, lsb ? rev(~tx) : ~tx);
      rchk("sts", 5'h08, 8'h00);
   endtask : t_master

   task automatic t_irq;
      sampleRise <= 1'b1;
      slvTx <= 8'h81;
      wr(5'h04, 8'h02);
      `CHK("level", 2'h2, irqLevel)
      wr(5'h00, 8'h50);
      ssLevelUser <= 1'b0;
      wr(5'h0c, 8'h11);
      wr(5'h0c, 8'h22);
      waitDone;
      ssLevelUser <= 1'b1;
      repeat (2) @(posedge mclk);
      `CHK("irq", 1'b1, irqReq)
      irqAck <= 1'b1;
      @(posedge mclk);
      irqAck <= 1'b0;
      repeat (3) @(posedge mclk);
      `CHK("irq ack", 1'b0, irqReq)
      `CHK("kept tx", 8'h11, slvRx)
      rchk("collide", 5'h08, 8'h40);
      rchk("rx", 5'h0c, 8'h81);
      rchk("cleared", 5'h08, 8'h00);
      wr(5'h04, 8'h00);
   endtask : t_irq

   task automatic t_fault;
      logic [31:0] d;
      logic [1:0]  r;
      wr(5'h00, 8'h50);
      ssDirUser <= 1'b0;
      tbSs_n <= 1'b0;
      repeat (4) @(posedge mclk);
      rchk("to slave", 5'h00, 8'h40);
      rchk("flag", 5'h08, 8'h80);
      tbSs_n <= 1'b1;
      ssDirUser <= 1'b1;
      rd(5'h0c, d, r);
   endtask : t_fault

   task automatic pulse(input logic b, output logic m);
      tbMosi <= b;
      repeat (6) @(posedge mclk);
      m = misoIn;
      tbSck <= 1'b1;
      repeat (6) @(posedge mclk);
      tbSck <= 1'b0;
   endtask : pulse

   task automatic t_slave;
      logic [7:0] q, pat;
      logic       m;
      pat = 8'h5a;
      misoDirUser <= 1'b1;
      wr(5'h00, 8'h40);
      tbSs_n <= 1'b0;
      for (int i = 0; i < 3; i++) pulse(1'b1, m);
      tbSs_n <= 1'b1;
      for (int i = 0; i < 2; i++) pulse(1'b0, m);
      `CHK("released", 1'b0, misoOe)
      wr(5'h0c, 8'h96);
      nDma = 0;
      tbSs_n <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         pulse(pat[i], m);
         q[i] = m;
      end
      `CHK("miso oe", 1'b1, misoOe)
      tbSs_n <= 1'b1;
      `CHK("miso", 8'h96, q)
      `CHK("dma", 1, nDma)
      rchk("slv done", 5'h08, 8'h80);
      rchk("slv rx", 5'h0c, 8'h5a);
   endtask : t_slave

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_of_test

   // Stop a hung run.
   initial begin
      repeat (60000) @(posedge mclk);
      err_total++;
      end_of_test;
   end

   // Reset, then run every scenario.
   initial begin
      {rst_n, awvalid, wvalid, bready, arvalid, rready, irqAck} = '0;
      {awaddr, araddr, wdata, tbSck, tbMosi, misoDirUser, slvTx} = '0;
      {mosiDirUser, sckDirUser, ssDirUser, ssLevelUser, tbSs_n} = '1;
      {err_total, n_tests, nDma} = '0;
      wstrb = 4'hf;
      sampleRise = 1'b1;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      t_reset;
      t_master(2'h0, 1'b0, 1'b0, 2'h0, 8'ha5);
      t_master(2'h1, 1'b1, 1'b1, 2'h0, 8'h3c);
      t_master(2'h2, 1'b0, 1'b1, 2'h1, 8'hc1);
      t_master(2'h3, 1'b1, 1'b0, 2'h1, 8'h0e);
      t_master(2'h0, 1'b0, 1'b0, 2'h3, 8'h69);
      t_master(2'h1, 1'b0, 1'b1, 2'h2, 8'hb4);
      t_irq;
      t_fault;
      t_slave;
      end_of_test;
   end
endmodule : test_spi_master_slave_port
